// File: hdl/smap_consts.svh
// Timing and protocol constants for the serial memory access port master.
// Assumes inclusion by bare name from hdl/ files only.
`ifndef SMAP_CONSTS_SVH
`define SMAP_CONSTS_SVH
`define SMAP_CLK_MHZ        50
`define SMAP_SCK_HALF_NS    80
`define SMAP_SCK_HALF_CYC   ((`SMAP_SCK_HALF_NS * `SMAP_CLK_MHZ + 999) / 1000)
`define SMAP_EDGES_PER_BYTE 16
`define SMAP_OP_READ_BYTE   8'h13
`define SMAP_OP_READ_ARRAY  8'h03
`define SMAP_OP_WRITE_BYTE  8'h12
`define SMAP_OP_WRITE_ARRAY 8'h02
`define SMAP_HDR_BYTES      3
`endif

// File: hdl/smap_pkg.sv
// Types shared by the serial memory access port master.
// Assumes nothing of its surroundings.
package smap_pkg;
	typedef enum logic [1:0] {
		SMAP_CMD_READ_BYTE   = 2'h0,
		SMAP_CMD_READ_ARRAY  = 2'h1,
		SMAP_CMD_WRITE_BYTE  = 2'h2,
		SMAP_CMD_WRITE_ARRAY = 2'h3
	} smap_cmd_t;
	typedef enum logic [2:0] {
		SMAP_ST_IDLE  = 3'h0,
		SMAP_ST_LEAD  = 3'h1,
		SMAP_ST_BYTE  = 3'h2,
		SMAP_ST_NEXT  = 3'h3,
		SMAP_ST_TRAIL = 3'h4
	} smap_state_t;
endpackage : smap_pkg

// File: hdl/smap_byte_if.sv
// Byte shifter handshake between the sequencer and the bit engine.
// Assumes one clock domain shared by both modports.
`timescale 1ns/10ps
interface smap_byte_if;
	logic       start;
	logic [7:0] tx_byte;
	logic       done;
	logic [7:0] rx_byte;
	logic       busy;
	modport ctrl (output start, output tx_byte, input done, input rx_byte, input busy);
	modport eng  (input start, input tx_byte, output done, output rx_byte, output busy);
endinterface : smap_byte_if

// File: hdl/smap_sync.sv
// Two-flop synchroniser for the serial data input.
// Assumes an asynchronous input pin.
`timescale 1ns/10ps
module smap_sync (
	input  wire logic i_clk,
	input  wire logic i_nrst,
	input  wire logic i_d,
	output logic      o_q
);
	logic meta_q;
	// Only the second flop is read downstream
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			meta_q <= 1'b0;
			o_q    <= 1'b0;
		end else begin
			meta_q <= i_d;
			o_q    <= meta_q;
		end
	end
endmodule : smap_sync

// File: hdl/smap_byte_eng.sv
// Bit engine: shifts one byte out and in over 16 clock edges, MSB first.
// Assumes start is a one-cycle pulse while busy is low; i_miso is synchronised.
`timescale 1ns/10ps
`include "smap_consts.svh"
module smap_byte_eng import smap_pkg::*; #(
	parameter int HALF_CYC = `SMAP_SCK_HALF_CYC
) (
	input  wire logic  i_clk,
	input  wire logic  i_nrst,
	input  wire logic  i_cpol,
	input  wire logic  i_cpha,
	input  wire logic  i_miso,
	output logic       o_sck,
	output logic       o_mosi,
	smap_byte_if.eng   bif
);
	localparam int CW = $clog2(HALF_CYC + 1);
	logic [CW-1:0] div_q;
	logic [4:0]    edge_q;
	logic [7:0]    tx_q;
	logic [7:0]    rx_q;
	logic          samp_q;
	logic          fin_q;
	logic          run_q;
	logic          phase_q;
	logic          tick;
	logic          odd_edge;
	logic          sample_now;

	assign tick       = run_q && (div_q == CW'(HALF_CYC - 1));
	assign odd_edge   = !edge_q[0];
	// Sample on odd edges with phase 0, on even edges with phase 1
	assign sample_now = tick && (odd_edge ^ i_cpha);
	assign bif.busy   = run_q;
	assign o_sck      = phase_q ^ i_cpol;

	// Half-period divider; the master makes the link clock itself
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			div_q <= '0;
		end else if (!run_q || tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + CW'(1);
		end
	end

	// Edge counter and clock phase
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			run_q   <= 1'b0;
			edge_q  <= '0;
			phase_q <= 1'b0;
		end else if (bif.start && !run_q) begin
			run_q   <= 1'b1;
			edge_q  <= '0;
			phase_q <= 1'b0;
		end else if (tick) begin
			phase_q <= !phase_q;
			edge_q  <= edge_q + 5'h01;
			if (edge_q == 5'(`SMAP_EDGES_PER_BYTE - 1)) begin
				run_q <= 1'b0;
			end
		end
	end

	// Shift out: phase 0 presents bit 7 at start, phase 1 on the first edge
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tx_q   <= 8'h00;
			o_mosi <= 1'b0;
		end else if (bif.start && !run_q) begin
			tx_q   <= bif.tx_byte;
			o_mosi <= i_cpha ? 1'b0 : bif.tx_byte[7];
		end else if (tick && !(odd_edge ^ i_cpha)) begin
			if (i_cpha) begin
				o_mosi <= tx_q[7];
				tx_q   <= {tx_q[6:0], 1'b0};
			end else if (edge_q != 5'(`SMAP_EDGES_PER_BYTE - 1)) begin
				o_mosi <= tx_q[6];
				tx_q   <= {tx_q[6:0], 1'b0};
			end
		end
	end

	// Shift in, then hand over the whole byte one cycle after the closing edge.
	// Phase 0 has its last sample an edge earlier, but waiting for the closing
	// edge keeps the next start from landing on a byte that is still running.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rx_q        <= 8'h00;
			samp_q      <= 1'b0;
			fin_q       <= 1'b0;
			bif.rx_byte <= 8'h00;
			bif.done    <= 1'b0;
		end else begin
			samp_q   <= sample_now;
			fin_q    <= tick && (edge_q == 5'(`SMAP_EDGES_PER_BYTE - 1));
			bif.done <= 1'b0;
			if (samp_q) begin
				rx_q <= {rx_q[6:0], i_miso};
			end
			// Phase 1 takes its last sample in the handover cycle itself
			if (fin_q) begin
				bif.rx_byte <= samp_q ? {rx_q[6:0], i_miso} : rx_q;
				bif.done    <= 1'b1;
			end
		end
	end

	// A byte always runs its full count of link clock edges
	a_byte_len: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$fell(run_q) |-> edge_q == 5'(`SMAP_EDGES_PER_BYTE))
		else $error("byte shifter stopped early");
	a_sck_idle: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!run_q && !bif.start |-> o_sck == i_cpol)
		else $error("link clock not at idle level");
endmodule : smap_byte_eng

// File: hdl/smap_master.sv
// Host controller driving the device's serial memory access port as link master.
// Assumes a device slave on the four link pins; user side is one command at a time.
`timescale 1ns/10ps
`include "smap_consts.svh"
module smap_master import smap_pkg::*; #(
	parameter int HALF_CYC = `SMAP_SCK_HALF_CYC,
	parameter int LEN_W    = 12,
	parameter int CTRL_TOP = 'h015
) (
	input  wire logic             i_clk,
	input  wire logic             i_nrst,
	input  wire logic             i_cpol,
	input  wire logic             i_cpha,
	input  wire logic             i_cmd_valid,
	input  wire smap_cmd_t        i_cmd,
	input  wire logic [15:0]      i_addr,
	input  wire logic [LEN_W-1:0] i_len,
	output logic                  o_cmd_ready,
	input  wire logic             i_wr_valid,
	input  wire logic [7:0]       i_wr_data,
	output logic                  o_wr_ready,
	output logic                  o_rd_valid,
	output logic [7:0]            o_rd_data,
	output logic                  o_done,
	output logic                  o_spi_select_n,
	output logic                  o_sck,
	output logic                  o_mosi,
	input  wire logic             i_miso
);
	localparam int CW_L = $clog2(HALF_CYC + 1);
	smap_byte_if bif ();
	smap_state_t       st_q;
	smap_cmd_t         cmd_q;
	logic [15:0]       addr_q;
	logic [LEN_W-1:0]  left_q;
	logic [1:0]        hdr_q;
	logic [7:0]        tx_q;
	logic [CW_L-1:0]   wait_q;
	logic              start_q;
	logic              miso_s;
	logic              is_read;
	logic              is_array;
	logic              wait_end;

	// Opcode for each user command
	function automatic logic [7:0] smap_opcode(input smap_cmd_t c);
		unique case (c)
			SMAP_CMD_READ_BYTE:   smap_opcode = `SMAP_OP_READ_BYTE;
			SMAP_CMD_READ_ARRAY:  smap_opcode = `SMAP_OP_READ_ARRAY;
			SMAP_CMD_WRITE_BYTE:  smap_opcode = `SMAP_OP_WRITE_BYTE;
			SMAP_CMD_WRITE_ARRAY: smap_opcode = `SMAP_OP_WRITE_ARRAY;
		endcase
	endfunction : smap_opcode

	assign is_read  = (cmd_q == SMAP_CMD_READ_BYTE) || (cmd_q == SMAP_CMD_READ_ARRAY);
	assign is_array = (cmd_q == SMAP_CMD_READ_ARRAY) || (cmd_q == SMAP_CMD_WRITE_ARRAY);
	assign wait_end = (wait_q == CW_L'(HALF_CYC - 1));

	// Miso comes from another domain
	smap_sync u_sync (
		.i_clk  (i_clk),
		.i_nrst (i_nrst),
		.i_d    (i_miso),
		.o_q    (miso_s)
	);

	smap_byte_eng #(
		.HALF_CYC (HALF_CYC)
	) u_eng (
		.i_clk  (i_clk),
		.i_nrst (i_nrst),
		.i_cpol (i_cpol),
		.i_cpha (i_cpha),
		.i_miso (miso_s),
		.o_sck  (o_sck),
		.o_mosi (o_mosi),
		.bif    (bif)
	);

	assign bif.start   = start_q;
	assign bif.tx_byte = tx_q;
	assign o_cmd_ready = (st_q == SMAP_ST_IDLE);
	// Write data is taken only between bytes, once the header is out
	// No offer is taken once the count is spent, or a byte would be swallowed
	assign o_wr_ready  = (st_q == SMAP_ST_NEXT) && !is_read && (hdr_q == 2'h3) && !start_q &&
	                     (left_q != '0);

	// Half-period guard counter around select edges
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wait_q <= '0;
		end else if ((st_q == SMAP_ST_LEAD || st_q == SMAP_ST_TRAIL) && !wait_end) begin
			wait_q <= wait_q + CW_L'(1);
		end else begin
			wait_q <= '0;
		end
	end

	// Sequencer: select, header bytes, data bytes, release
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_q           <= SMAP_ST_IDLE;
			cmd_q          <= SMAP_CMD_READ_BYTE;
			addr_q         <= 16'h0000;
			left_q         <= '0;
			hdr_q          <= 2'h0;
			tx_q           <= 8'h00;
			start_q        <= 1'b0;
			o_spi_select_n <= 1'b1;
			o_done         <= 1'b0;
		end else begin
			start_q <= 1'b0;
			o_done  <= 1'b0;
			unique case (st_q)
				SMAP_ST_IDLE: begin
					if (i_cmd_valid) begin
						cmd_q          <= i_cmd;
						addr_q         <= i_addr;
						// Single commands move one byte whatever length is given
						left_q         <= (i_cmd == SMAP_CMD_READ_BYTE ||
						                   i_cmd == SMAP_CMD_WRITE_BYTE ||
						                   i_len == '0) ? LEN_W'(1) : i_len;
						o_spi_select_n <= 1'b0;
						hdr_q          <= 2'h0;
						st_q           <= SMAP_ST_LEAD;
					end
				end
				SMAP_ST_LEAD: begin
					// First edge comes a full period after select falls: this half period, then the engine's own
					if (wait_end) begin
						tx_q    <= smap_opcode(cmd_q);
						start_q <= 1'b1;
						st_q    <= SMAP_ST_BYTE;
					end
				end
				SMAP_ST_BYTE: begin
					if (bif.done) begin
						st_q <= SMAP_ST_NEXT;
						if (hdr_q == 2'h3) begin
							left_q <= left_q - LEN_W'(1);
						end
					end
				end
				SMAP_ST_NEXT: begin
					if (hdr_q != 2'h3) begin
						// Address high byte then low byte
						hdr_q <= hdr_q + 2'h1;
						if (hdr_q == 2'h2 && !is_read) begin
							st_q <= (left_q == '0) ? SMAP_ST_TRAIL : SMAP_ST_NEXT;
						end else begin
							tx_q    <= (hdr_q == 2'h0) ? addr_q[15:8] :
							           (hdr_q == 2'h1) ? addr_q[7:0] : 8'h00;
							start_q <= 1'b1;
							st_q    <= SMAP_ST_BYTE;
						end
					end else if (left_q == '0) begin
						st_q <= SMAP_ST_TRAIL;
					end else if (is_read) begin
						tx_q    <= 8'h00;
						start_q <= 1'b1;
						st_q    <= SMAP_ST_BYTE;
					end else if (i_wr_valid) begin
						tx_q    <= i_wr_data;
						start_q <= 1'b1;
						st_q    <= SMAP_ST_BYTE;
					end
				end
				SMAP_ST_TRAIL: begin
					// Select stays low until the last edge plus half a period
					if (wait_end) begin
						o_spi_select_n <= 1'b1;
						o_done         <= 1'b1;
						st_q           <= SMAP_ST_IDLE;
					end
				end
				default: begin
					st_q <= SMAP_ST_IDLE;
				end
			endcase
		end
	end

	// Read bytes handed to the user; header-time bytes are dropped
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rd_valid <= 1'b0;
			o_rd_data  <= 8'h00;
		end else begin
			o_rd_valid <= 1'b0;
			if (bif.done && st_q == SMAP_ST_BYTE && hdr_q == 2'h3 && is_read) begin
				o_rd_valid <= 1'b1;
				o_rd_data  <= bif.rx_byte;
			end
		end
	end


	// A byte in flight always has select low under it
	a_sel_held: assert property (@(posedge i_clk) disable iff (!i_nrst)
		bif.busy |-> !o_spi_select_n)
		else $error("select released during a byte");

	// The lead-in guard keeps the first edge clear of the select edge
	a_sel_lead: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$fell(o_spi_select_n) |-> !start_q [*2])
		else $error("byte started too soon after select");

	// Single commands never carry more than one data byte
	a_single_len: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(st_q == SMAP_ST_LEAD) && !is_array |-> left_q == LEN_W'(1))
		else $error("single command longer than one byte");

	// Streaming reads through the control area would prefetch past it
	a_ctrl_area: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(st_q == SMAP_ST_LEAD) && cmd_q == SMAP_CMD_READ_ARRAY
		|-> addr_q[11:0] > 12'(CTRL_TOP) || left_q == LEN_W'(1))
		else $error("array read started in the control area");

	// Done marks the very cycle in which select goes back high
	a_done_sel: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_done |-> o_spi_select_n && $past(!o_spi_select_n))
		else $error("done without select release");

	// The link clock rests at its idle level whenever the device is deselected
	a_sck_quiet: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_spi_select_n |-> o_sck == i_cpol)
		else $error("link clock moved while deselected");

	// Read pulses come only in reads and last one cycle
	a_rd_only: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_rd_valid |-> is_read ##1 !o_rd_valid)
		else $error("read data outside a read");

	// Write data is only offered between bytes of a selected frame
	a_wr_gate: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_wr_ready |-> !bif.busy && !o_spi_select_n)
		else $error("write data taken mid byte");

	// A taken write byte goes onto the link two cycles later
	a_wr_start: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_wr_ready && i_wr_valid |-> ##2 bif.busy)
		else $error("taken write byte never started");

	// A taken command pulls select low on the next edge
	a_sel_fall: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_cmd_valid && o_cmd_ready |=> !o_spi_select_n)
		else $error("command taken without selecting the device");

	// Outside reset, select only rises at the orderly end of a frame, never on its own
	a_rose_done: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$rose(o_spi_select_n) |-> o_done)
		else $error("select raised outside the end of a frame");

	// Link clock edges only happen inside a selected frame
	a_sck_sel: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$changed(o_sck) && $stable(i_cpol) |-> !o_spi_select_n)
		else $error("link clock edge outside a frame");

	// A zero length is turned into one byte before the frame opens
	a_lead_len: assert property (@(posedge i_clk) disable iff (!i_nrst)
		st_q == SMAP_ST_LEAD |-> left_q != '0)
		else $error("frame opened with no bytes to move");

	// Every requested data byte has moved by the time the frame closes
	a_done_left: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_done |-> left_q == '0)
		else $error("frame closed with bytes still owed");

	// The trailing guard only runs once the last edge is out
	a_trail_quiet: assert property (@(posedge i_clk) disable iff (!i_nrst)
		st_q == SMAP_ST_TRAIL |-> !bif.busy)
		else $error("select release started while a byte runs");

	// Phase 0 shows the top bit before the first edge of each byte
	a_mosi_first: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$rose(bif.busy) && !i_cpha |-> o_mosi == tx_q[7])
		else $error("first bit not presented ahead of the first edge");

	// Only one command at a time: idle means the shifter is quiet
	a_cmd_free: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_cmd_ready |-> !bif.busy)
		else $error("command offered while a byte runs");

	// Stalls between bytes leave the clock parked at its idle level
	a_gap_idle: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!bif.busy && !start_q && !o_spi_select_n |-> o_sck == i_cpol)
		else $error("link clock not parked during a stall");
endmodule : smap_master

// File: dv/smap_dev_model.sv
// Behavioural model of the memory device behind the serial port, slave side only.
// Assumes 4 kB memory mode unless AMASK is narrowed; the bench preloads mem.
`timescale 1ns/10ps
module smap_dev_model #(
	parameter int AMASK = 'hFFF
) (
	input  wire logic i_cpol,
	input  wire logic i_cpha,
	input  wire logic i_spi_select_n,
	input  wire logic i_sck,
	input  wire logic i_mosi,
	output logic      o_miso
);
	logic [7:0]  mem [0:4095];
	logic [7:0]  sh_q;
	logic [7:0]  ins_q;
	logic [7:0]  tx_q;
	logic [11:0] ptr_q;
	int          nbit;
	int          nbyte;
	bit          lead;
	initial o_miso = 1'b0;
	// Completed byte moves from the shifter into the decode state
	task automatic take_byte();
		nbyte++;
		case (nbyte)
			1: ins_q = sh_q;
			2: ptr_q[11:8] = sh_q[3:0];
			3: ptr_q[7:0] = sh_q;
			default: if (ins_q == 8'h02 || (ins_q == 8'h12 && nbyte == 4)) begin
				mem[ptr_q & AMASK] = sh_q;
				ptr_q = (ptr_q + 12'h001) & AMASK;
			end else if (ins_q == 8'h03) begin
				ptr_q = (ptr_q + 12'h001) & AMASK;
			end
		endcase
		tx_q = mem[ptr_q & AMASK];
	endtask : take_byte
	// A fresh selection drops any partial byte and header state
	always @(negedge i_spi_select_n) begin
		nbit = 0;
		nbyte = 0;
		tx_q = 8'h00;
		o_miso = tx_q[7];
	end
	// Released line shows the inverse of its last level so a stale value never passes
	always @(posedge i_spi_select_n) o_miso = ~o_miso;
	// Leading or trailing edge decides sampling against shifting
	always @(i_sck) if (!i_spi_select_n) begin
		lead = (i_sck != i_cpol);
		if (lead ^ i_cpha) begin
			sh_q = {sh_q[6:0], i_mosi};
			nbit++;
			if (nbit == 8) begin
				nbit = 0;
				take_byte();
			end
		end else if (nbyte >= 3 && (ins_q == 8'h03 || (ins_q == 8'h13 && nbyte == 3))) begin
			o_miso = tx_q[7 - nbit];
		end else begin
			o_miso = ~o_miso;
		end
	end
endmodule : smap_dev_model

// File: dv/spi_slave_memory_access_port_bench.sv
// Self-checking bench for the serial memory access port master and a device model.
// Assumes the model memory starts as a copy of the bench's reference image.
`timescale 1ns/10ps
module spi_slave_memory_access_port_bench import smap_pkg::*;;
	logic        i_clk;
	logic        i_nrst;
	logic        i_cpol;
	logic        i_cpha;
	logic        i_cmd_valid;
	smap_cmd_t   i_cmd;
	logic [15:0] i_addr;
	logic [11:0] i_len;
	logic        i_wr_valid;
	logic [7:0]  i_wr_data;
	logic        o_cmd_ready;
	logic        o_wr_ready;
	logic        o_rd_valid;
	logic [7:0]  o_rd_data;
	logic        o_done;
	logic        o_spi_select_n;
	logic        o_sck;
	logic        o_mosi;
	logic        miso;
	logic [7:0]  ref_mem [0:4095];
	logic [7:0]  wq [$];
	logic [7:0]  rdq [$];
	logic [15:0] a;
	int          n;
	int          seed = 44;
	int          num_errors = 0;
	int          n_compared = 0;
	int          cyc = 0;
	smap_master #(.HALF_CYC(4)) u_smap_master (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_cpol(i_cpol), .i_cpha(i_cpha),
		.i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_addr(i_addr), .i_len(i_len),
		.o_cmd_ready(o_cmd_ready), .i_wr_valid(i_wr_valid), .i_wr_data(i_wr_data),
		.o_wr_ready(o_wr_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
		.o_done(o_done), .o_spi_select_n(o_spi_select_n), .o_sck(o_sck),
		.o_mosi(o_mosi), .i_miso(miso)
	);
	smap_dev_model u_smap_dev_model (
		.i_cpol(i_cpol), .i_cpha(i_cpha), .i_spi_select_n(o_spi_select_n),
		.i_sck(o_sck), .i_mosi(o_mosi), .o_miso(miso)
	);
	// Only the low twelve address bits reach memory in 4 kB mode
	function automatic logic [11:0] ea(input logic [15:0] x);
		return x[11:0];
	endfunction : ea
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic conclude();
		$display("compared %0d mismatched %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : conclude
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	// Hang guard: the whole run needs well under this many cycles
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 80000) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, cyc, 0);
			conclude();
		end
	end
	always @(posedge i_clk) if (o_rd_valid === 1'b1) rdq.push_back(o_rd_data);
	// Write bytes offered after random gaps that close within the byte in flight, so the link does not stall between bytes
	always @(posedge i_clk) begin
		if (i_wr_valid && o_wr_ready === 1'b1) begin
			void'(wq.pop_front());
			i_wr_valid <= 1'b0;
		end else if (!i_wr_valid && wq.size() > 0 && $random(seed) % 2 == 0) begin
			i_wr_valid <= 1'b1;
			i_wr_data <= wq[0];
		end
	end
	task automatic run(input smap_cmd_t c, input logic [15:0] ad, input int len);
		int         t;
		logic [7:0] d;
		rdq.delete();
		if (c == SMAP_CMD_READ_BYTE || c == SMAP_CMD_WRITE_BYTE) len = 1;
		for (int k = 0; k < len && c >= SMAP_CMD_WRITE_BYTE; k++) begin
			d = 8'($random(seed));
			wq.push_back(d);
			ref_mem[ea(ad + 16'(k))] = d;
		end
		@(posedge i_clk);
		i_cmd_valid <= 1'b1;
		i_cmd <= c;
		i_addr <= ad;
		i_len <= 12'(len);
		do @(posedge i_clk); while (o_cmd_ready !== 1'b1);
		i_cmd_valid <= 1'b0;
		t = 0;
		do begin
			@(posedge i_clk);
			t++;
		end while (o_done !== 1'b1 && t < 3000);
		chk(8'(t < 3000), 8'h01);
		repeat (2) @(posedge i_clk);
		if (c <= SMAP_CMD_READ_ARRAY) begin
			chk(8'(rdq.size()), 8'(len));
			for (int k = 0; k < len && k < rdq.size(); k++) begin
				chk(rdq[k], ref_mem[ea(ad + 16'(k))]);
			end
		end
	endtask : run
	initial begin
		i_nrst = 1'b0;
		i_cpol = 1'b0;
		i_cpha = 1'b0;
		i_cmd_valid = 1'b0;
		i_cmd = SMAP_CMD_READ_BYTE;
		i_addr = 16'h0000;
		i_len = 12'h000;
		i_wr_valid = 1'b0;
		i_wr_data = 8'h00;
		for (int i = 0; i < 4096; i++) begin
			ref_mem[i] = 8'($random(seed));
			u_smap_dev_model.mem[i] = ref_mem[i];
		end
		repeat (3) @(posedge i_clk);
		i_nrst <= 1'b1;
		// All four clock formats, each code twice per format, clear of the control area
		for (int m = 0; m < 4; m++) begin
			@(posedge i_clk);
			i_cpol <= m[1];
			i_cpha <= m[0];
			repeat (3) @(posedge i_clk);
			chk(8'(o_sck), 8'(i_cpol));
			chk(8'(o_spi_select_n), 8'h01);
			for (int k = 0; k < 2; k++) begin
				a = {4'($random(seed)), 12'h100 + 12'($random(seed) & 'h7FF)};
				n = 1 + ($random(seed) & 7);
				run(SMAP_CMD_WRITE_ARRAY, a, n);
				run(SMAP_CMD_READ_ARRAY, a ^ 16'hF000, n);
				run(SMAP_CMD_WRITE_BYTE, a + 16'h0009, 4);
				run(SMAP_CMD_READ_BYTE, a + 16'h0009, 1);
			end
			$display("format %0d done", m);
		end
		// Array write across the top of memory, then the wrapped bytes read singly
		run(SMAP_CMD_WRITE_ARRAY, 16'h3FFE, 4);
		run(SMAP_CMD_READ_BYTE, 16'h7000, 1);
		run(SMAP_CMD_READ_BYTE, 16'h0001, 1);
		run(SMAP_CMD_READ_ARRAY, 16'hAFFD, 3);
		$display("wrap done");
		// Reset in mid-read must release select and leave the device ready again
		@(posedge i_clk);
		i_cmd_valid <= 1'b1;
		i_cmd <= SMAP_CMD_READ_ARRAY;
		i_addr <= 16'h0200;
		i_len <= 12'h008;
		repeat (300) @(posedge i_clk);
		i_cmd_valid <= 1'b0;
		i_nrst <= 1'b0;
		@(posedge i_clk);
		i_nrst <= 1'b1;
		@(posedge i_clk);
		chk(8'(o_spi_select_n), 8'h01);
		run(SMAP_CMD_READ_BYTE, 16'h0203, 1);
		$display("abort done");
		conclude();
	end
endmodule : spi_slave_memory_access_port_bench
